/* File: common/lsd_pkg.sv */
// types shared by the serial led sink driver
`include "lsd_regs.svh"

package lsd_pkg;

    // =================================================================
    // programming mode as seen on the mode pin
    typedef enum logic [0:0] {
        LSD_MODE_GRAY = 1'b0,
        LSD_MODE_DOTC = 1'b1
    } lsd_mode_t;

    // =================================================================
    // state of the top module, apart from the reset flops and the channel delay lines
    typedef struct packed {
        logic [2:0] sclk_s;
        logic [1:0] ser_in_s;
        logic [2:0] latch_s;
        logic [1:0] mode_s;
        logic [1:0] blank_s;
        logic [2:0] pwm_s;
        logic [1:0] temp_s;
        logic [1:0] errpin_s;
        logic [`LSD_NUM_CH-1:0] lowv_a;
        logic [`LSD_NUM_CH-1:0] lowv_b;
        logic [`LSD_SR_GRAY_LEN-1:0] sr;
        logic [`LSD_NUM_CH-1:0][`LSD_GRAY_W-1:0] gray;
        logic [`LSD_NUM_CH-1:0][`LSD_DOTC_W-1:0] dotc;
        logic [`LSD_GRAY_CNT_W-1:0] gray_cnt;
        logic [`LSD_NUM_CH-1:0] raw_on;
        logic [`LSD_NUM_CH-1:0] chan_out;
        logic [`LSD_NUM_CH-1:0][`LSD_DET_CNT_W-1:0] det_cnt;
        logic therm_prev;
        logic open_prev;
        logic [`LSD_IRQ_W-1:0] irq_stat;
        logic [`LSD_IRQ_W-1:0] irq_mask;
        logic ctrl_blank;
        logic err_oe_n;
        logic err_level;
        logic ser_out;
        logic irq;
        logic aw_full;
        logic [7:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } lsd_state_t;

endpackage : lsd_pkg

/* File: common/lsd_regs.svh */
// constants for the serial led sink driver: sizes, status layout, timing, register map
`ifndef LSD_REGS_SVH
`define LSD_REGS_SVH

// =====================================================================
// channel and packet sizes
`define LSD_NUM_CH 16
`define LSD_GRAY_W 12
`define LSD_DOTC_W 6
`define LSD_SR_GRAY_LEN 192
`define LSD_SR_DOTC_LEN 96
`define LSD_GRAY_CNT_W 13
`define LSD_GRAY_CNT_MAX 13'h1000
`define LSD_DET_CNT_W 6

// =====================================================================
// status packet layout
`define LSD_STP_OPEN_LSB 0
`define LSD_STP_THERM_BIT 16
`define LSD_STP_DOTC_LSB 24

// =====================================================================
// timing
`define LSD_CLK_PERIOD_NS 20
`define LSD_CHAN_DELAY_NS 20
`define LSD_CHAN_DELAY_CYC ((`LSD_CHAN_DELAY_NS + `LSD_CLK_PERIOD_NS - 1) / `LSD_CLK_PERIOD_NS)
`define LSD_OPEN_DET_NS 1000
`define LSD_OPEN_DET_CYC ((`LSD_OPEN_DET_NS + `LSD_CLK_PERIOD_NS - 1) / `LSD_CLK_PERIOD_NS)

// =====================================================================
// register map, byte addresses
`define LSD_REG_CTRL 8'h00
`define LSD_REG_STATUS 8'h04
`define LSD_REG_IRQ_STAT 8'h08
`define LSD_REG_IRQ_MASK 8'h0C
`define LSD_CTRL_BLANK_BIT 0
`define LSD_STAT_THERM_BIT 16
`define LSD_STAT_MODE_BIT 17
`define LSD_STAT_ERRPIN_BIT 18
`define LSD_STAT_LATCH_BIT 19
`define LSD_IRQ_W 3
`define LSD_IRQ_THERM_BIT 0
`define LSD_IRQ_OPEN_BIT 1
`define LSD_IRQ_LATCH_BIT 2
`define LSD_CTRL_RST 1'b0
`define LSD_IRQ_MASK_RST 3'h0
`define LSD_RESP_OKAY 2'b00
`define LSD_RESP_SLVERR 2'b10

`endif

/* File: hdl/lsd_delay_line.sv */
// fixed-depth single-bit delay line used for staggered channel switching
`timescale 1ns/1ps

module lsd_delay_line #(
    parameter int DEPTH = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_d,
    output logic o_q
);

    typedef struct packed {
        logic [DEPTH:0] taps;
    } lsd_dly_state_t;

    lsd_dly_state_t st;
    lsd_dly_state_t next_st;
    logic [DEPTH+1:0] chain;

    // =================================================================
    // chain[k] is the input delayed by k cycles; depth 0 passes through
    always_comb begin
        chain = {st.taps, i_d};
        next_st.taps = chain[DEPTH:0];
        o_q = chain[DEPTH];
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '0;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

endmodule : lsd_delay_line

/* File: hdl/lsd_top.sv */
// serial led sink driver control: shift register, latches, pwm, error flags, axi-lite
//
// Summary of operation
// - each shift clock rising edge shifts the serial input into the shift register
// - host pulses latch high; registers follow shift register while latch stays high
// - all serial words travel most significant bit first
// - shift register is 96 bits in dot-correction mode, 192 in grayscale mode
// - latched grayscale data replaces current values at once, mid-cycle included
// - shift register msb drives serial output for chaining and status readback
// - open-drain error output released normally, pulled low on thermal or open flag
// - blank pin high masks open-led flags from the error output
// - thermal flag follows over-temperature input and is readable in status data
// - open flag needs channel on, detection delay elapsed, and low output voltage
// - open flags captured into status data when latch falls after high in grayscale mode
// - channel n switches on and off n times 20 ns after channel 0
// - blanking high forces outputs off and resets the grayscale counter
// - mode low selects grayscale register, high selects dot-correction register
// - dot-correction packet holds 6 bits per channel, grayscale 12 bits
// - after grayscale latch, shift register holds open flags, thermal, dot correction
`timescale 1ns/1ps
`include "lsd_regs.svh"

module lsd_top (
    input wire logic I_CORE_CLK,
    input wire logic I_RST_B,
    input wire logic I_CE,
    input wire logic I_SHIFT_CLK,
    input wire logic I_SERIAL_IN,
    input wire logic I_LATCH_STROBE,
    input wire logic I_MODE,
    input wire logic I_BLANK,
    input wire logic I_PWM_COUNT_CLOCK,
    input wire logic I_OVER_TEMP,
    input wire logic [15:0] I_LOW_VOUT,
    input wire logic I_ERROR_OUT_N,
    output logic O_ERROR_OUT_N,
    output logic O_ERROR_OUT_N_OE,
    output logic O_SERIAL_OUT,
    output logic [15:0] O_CHANNEL_OUTPUT,
    output logic O_IRQ,
    input wire logic [7:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [7:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY
);

    lsd_pkg::lsd_state_t st;
    lsd_pkg::lsd_state_t next_st;
    logic rst_meta;
    logic rst_n;
    logic [`LSD_NUM_CH-1:0] dly_out;

    // =================================================================
    // reset release through two flops
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // =================================================================
    // staggered channel delay
    // gating happens before the delay so a short blank-low window keeps its width
    for (genvar n = 0; n < `LSD_NUM_CH; n++) begin : g_dly
        lsd_delay_line #(
            .DEPTH(n * `LSD_CHAN_DELAY_CYC)
        ) u_dly (
            .i_clk(I_CORE_CLK),
            .i_rst_n(rst_n),
            .i_ce(I_CE),
            .i_d(st.raw_on[n]),
            .o_q(dly_out[n])
        );
    end

    // =================================================================
    // next-state logic
    always_comb begin
        logic sclk_rise;
        logic latch_hi;
        logic latch_fall;
        logic pwm_rise;
        logic blank;
        logic therm;
        logic any_open;
        logic [`LSD_NUM_CH-1:0] open_live;
        logic [`LSD_IRQ_W-1:0] irq_clr;
        logic [`LSD_IRQ_W-1:0] irq_ev;
        logic [31:0] status_word;
        lsd_pkg::lsd_mode_t mode;
        sclk_rise = 1'b0;
        latch_hi = 1'b0;
        latch_fall = 1'b0;
        pwm_rise = 1'b0;
        blank = 1'b0;
        therm = 1'b0;
        any_open = 1'b0;
        open_live = '0;
        irq_clr = '0;
        irq_ev = '0;
        status_word = 32'h0000_0000;
        mode = lsd_pkg::LSD_MODE_GRAY;
        next_st = st;

        // pin synchronisers; stage 0 feeds only stage 1
        next_st.sclk_s = {st.sclk_s[1:0], I_SHIFT_CLK};
        next_st.ser_in_s = {st.ser_in_s[0], I_SERIAL_IN};
        next_st.latch_s = {st.latch_s[1:0], I_LATCH_STROBE};
        next_st.mode_s = {st.mode_s[0], I_MODE};
        next_st.blank_s = {st.blank_s[0], I_BLANK};
        next_st.pwm_s = {st.pwm_s[1:0], I_PWM_COUNT_CLOCK};
        next_st.temp_s = {st.temp_s[0], I_OVER_TEMP};
        next_st.errpin_s = {st.errpin_s[0], I_ERROR_OUT_N};
        next_st.lowv_a = I_LOW_VOUT;
        next_st.lowv_b = st.lowv_a;

        sclk_rise = st.sclk_s[1] & ~st.sclk_s[2];
        latch_hi = st.latch_s[1];
        latch_fall = ~st.latch_s[1] & st.latch_s[2];
        pwm_rise = st.pwm_s[1] & ~st.pwm_s[2];
        mode = lsd_pkg::lsd_mode_t'(st.mode_s[1]);
        blank = st.blank_s[1] | st.ctrl_blank;
        therm = st.temp_s[1];

        // open-led detection per channel
        for (int n = 0; n < `LSD_NUM_CH; n++) begin
            if (!st.chan_out[n]) begin
                next_st.det_cnt[n] = '0;
            end else if (st.det_cnt[n] != `LSD_DET_CNT_W'(`LSD_OPEN_DET_CYC)) begin
                next_st.det_cnt[n] = st.det_cnt[n] + `LSD_DET_CNT_W'(1);
            end
            open_live[n] = st.chan_out[n] & st.lowv_b[n]
                & (st.det_cnt[n] == `LSD_DET_CNT_W'(`LSD_OPEN_DET_CYC));
        end
        any_open = |open_live;

        // serial shift, msb enters first and ends at the top
        if (sclk_rise) begin
            next_st.sr = {st.sr[`LSD_SR_GRAY_LEN-2:0], st.ser_in_s[1]};
        end

        // transparent latch while the strobe is high
        if (latch_hi) begin
            for (int n = 0; n < `LSD_NUM_CH; n++) begin
                if (mode == lsd_pkg::LSD_MODE_DOTC) begin
                    next_st.dotc[n] = st.sr[n*`LSD_DOTC_W +: `LSD_DOTC_W];
                end else begin
                    next_st.gray[n] = st.sr[n*`LSD_GRAY_W +: `LSD_GRAY_W];
                end
            end
        end

        // status packet replaces the grayscale bits on strobe fall
        if (latch_fall && mode == lsd_pkg::LSD_MODE_GRAY) begin
            next_st.sr = '0;
            next_st.sr[`LSD_STP_OPEN_LSB +: `LSD_NUM_CH] = open_live;
            next_st.sr[`LSD_STP_THERM_BIT] = therm;
            for (int n = 0; n < `LSD_NUM_CH; n++) begin
                next_st.sr[`LSD_STP_DOTC_LSB + n*`LSD_DOTC_W +: `LSD_DOTC_W] =
                    st.dotc[n];
            end
        end

        // active length decides which bit leaves first
        if (mode == lsd_pkg::LSD_MODE_DOTC) begin
            next_st.ser_out = next_st.sr[`LSD_SR_DOTC_LEN-1];
        end else begin
            next_st.ser_out = next_st.sr[`LSD_SR_GRAY_LEN-1];
        end

        // grayscale counter saturates so a cycle does not restart by itself
        if (blank) begin
            next_st.gray_cnt = '0;
        end else if (pwm_rise && st.gray_cnt != `LSD_GRAY_CNT_MAX) begin
            next_st.gray_cnt = st.gray_cnt + `LSD_GRAY_CNT_W'(1);
        end
        for (int n = 0; n < `LSD_NUM_CH; n++) begin
            next_st.raw_on[n] = ~blank & (st.gray_cnt < {1'b0, st.gray[n]});
        end
        next_st.chan_out = dly_out;

        // error pin, open flags hidden while blank pin is high
        next_st.err_oe_n = ~(therm | (any_open & ~st.blank_s[1]));
        next_st.err_level = 1'b0;

        // ---------------------------------------------------------- axi write
        if (I_AWVALID && st.awready) begin
            next_st.aw_full = 1'b1;
            next_st.aw_addr = I_AWADDR;
        end
        if (I_WVALID && st.wready) begin
            next_st.w_full = 1'b1;
            next_st.w_data = I_WDATA;
            next_st.w_strb = I_WSTRB;
        end
        if (st.bvalid && I_BREADY) begin
            next_st.bvalid = 1'b0;
        end
        if (st.aw_full && st.w_full && !st.bvalid) begin
            next_st.aw_full = 1'b0;
            next_st.w_full = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = `LSD_RESP_OKAY;
            case ({st.aw_addr[7:2], 2'b00})
                `LSD_REG_CTRL: begin
                    if (st.w_strb[0]) begin
                        next_st.ctrl_blank = st.w_data[`LSD_CTRL_BLANK_BIT];
                    end
                end
                `LSD_REG_STATUS: begin
                end
                `LSD_REG_IRQ_STAT: begin
                    if (st.w_strb[0]) begin
                        irq_clr = st.w_data[`LSD_IRQ_W-1:0];
                    end
                end
                `LSD_REG_IRQ_MASK: begin
                    if (st.w_strb[0]) begin
                        next_st.irq_mask = st.w_data[`LSD_IRQ_W-1:0];
                    end
                end
                default: begin
                    next_st.bresp = `LSD_RESP_SLVERR;
                end
            endcase
        end
        next_st.awready = ~next_st.aw_full & ~next_st.bvalid;
        next_st.wready = ~next_st.w_full & ~next_st.bvalid;

        // ---------------------------------------------------------- axi read
        status_word[`LSD_NUM_CH-1:0] = open_live;
        status_word[`LSD_STAT_THERM_BIT] = therm;
        status_word[`LSD_STAT_MODE_BIT] = st.mode_s[1];
        status_word[`LSD_STAT_ERRPIN_BIT] = st.errpin_s[1];
        status_word[`LSD_STAT_LATCH_BIT] = latch_hi;
        if (st.rvalid && I_RREADY) begin
            next_st.rvalid = 1'b0;
        end
        if (I_ARVALID && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = `LSD_RESP_OKAY;
            case ({I_ARADDR[7:2], 2'b00})
                `LSD_REG_CTRL: begin
                    next_st.rdata = {31'h0000_0000, st.ctrl_blank};
                end
                `LSD_REG_STATUS: begin
                    next_st.rdata = status_word;
                end
                `LSD_REG_IRQ_STAT: begin
                    next_st.rdata = {29'h0000_0000, st.irq_stat};
                end
                `LSD_REG_IRQ_MASK: begin
                    next_st.rdata = {29'h0000_0000, st.irq_mask};
                end
                default: begin
                    next_st.rdata = 32'h0000_0000;
                    next_st.rresp = `LSD_RESP_SLVERR;
                end
            endcase
        end
        next_st.arready = ~next_st.rvalid;

        // ---------------------------------------------------------- interrupts
        // a new event beats a same-cycle clear
        next_st.therm_prev = therm;
        next_st.open_prev = any_open;
        irq_ev[`LSD_IRQ_THERM_BIT] = therm & ~st.therm_prev;
        irq_ev[`LSD_IRQ_OPEN_BIT] = any_open & ~st.open_prev;
        irq_ev[`LSD_IRQ_LATCH_BIT] = latch_fall;
        next_st.irq_stat = (st.irq_stat & ~irq_clr) | irq_ev;
        next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
    end

    // =================================================================
    // state register; clock enable freezes everything
    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.err_oe_n <= 1'b1;
            st.ctrl_blank <= `LSD_CTRL_RST;
            st.irq_mask <= `LSD_IRQ_MASK_RST;
        end else if (I_CE) begin
            st <= next_st;
        end
    end

    // =================================================================
    // outputs
    assign O_ERROR_OUT_N = st.err_level;
    assign O_ERROR_OUT_N_OE = st.err_oe_n;
    assign O_SERIAL_OUT = st.ser_out;
    assign O_CHANNEL_OUTPUT = st.chan_out;
    assign O_IRQ = st.irq;
    assign O_AWREADY = st.awready;
    assign O_WREADY = st.wready;
    assign O_BRESP = st.bresp;
    assign O_BVALID = st.bvalid;
    assign O_ARREADY = st.arready;
    assign O_RDATA = st.rdata;
    assign O_RRESP = st.rresp;
    assign O_RVALID = st.rvalid;

endmodule : lsd_top

/* File: verification/lsd_host_model.sv */
// host-side model of the serial shift, latch and mode pins
`timescale 1ns/1ps
module lsd_host_model (
    input wire logic i_clk,
    input wire logic i_serial_out,
    output logic o_shift_clk,
    output logic o_serial_in,
    output logic o_latch,
    output logic o_mode
);
    // =====
    // shift clock idles low between frames
    initial begin
        o_shift_clk = 1'b0;
        o_serial_in = 1'b0;
        o_latch = 1'b0;
        o_mode = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clk);
    endtask : wait_clk
    task automatic set_mode(input logic m);
        o_mode <= m;
        wait_clk(4);
    endtask : set_mode
    task automatic frame(input logic [191:0] d, input int n, output logic [191:0] q);
        q = '0;
        @(posedge i_clk);
        for (int i = n - 1; i >= 0; i--) begin
            o_serial_in <= d[i];
            wait_clk(4);
            q[i] = i_serial_out;
            o_shift_clk <= 1'b1;
            wait_clk(4);
            o_shift_clk <= 1'b0;
        end
        wait_clk(4);
    endtask : frame
    task automatic pulse();
        o_latch <= 1'b1;
        wait_clk(4);
        o_latch <= 1'b0;
        wait_clk(8);
    endtask : pulse
endmodule : lsd_host_model

/* File: verification/lsd_top_monitor.sv */
// port-level assertion checker for the led sink driver
`timescale 1ns/1ps
module lsd_top_monitor (
    input wire logic I_CORE_CLK,
    input wire logic I_RST_B,
    input wire logic I_BLANK,
    input wire logic I_OVER_TEMP,
    input wire logic [15:0] I_LOW_VOUT,
    input wire logic O_ERROR_OUT_N,
    input wire logic O_ERROR_OUT_N_OE,
    input wire logic [15:0] O_CHANNEL_OUTPUT,
    input wire logic I_AWVALID,
    input wire logic O_AWREADY,
    input wire logic I_WVALID,
    input wire logic O_WREADY,
    input wire logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic I_ARVALID,
    input wire logic O_ARREADY,
    input wire logic O_RVALID,
    input wire logic I_RREADY
);
    // =====
    // assumes clock enable held high
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_B);
    logic [4:0] blank_run;
    always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            blank_run <= 5'h00;
        end else if (!I_BLANK) begin
            blank_run <= 5'h00;
        end else if (blank_run != 5'h1F) begin
            blank_run <= blank_run + 5'h01;
        end
    end
    AST_ERR_LOW_ONLY: assert property (!O_ERROR_OUT_N_OE |-> !O_ERROR_OUT_N)
        else $error("error pin enabled with a high value");
    AST_THERM_PULL: assert property (I_OVER_TEMP [*8] |-> !O_ERROR_OUT_N_OE)
        else $error("error pin released during over-temperature");
    AST_ERR_RELEASE: assert property
        ((I_LOW_VOUT == 16'h0000 && !I_OVER_TEMP) [*8] |-> O_ERROR_OUT_N_OE)
        else $error("error pin pulled without a cause");
    AST_BLANK_MASK: assert property ((I_BLANK && !I_OVER_TEMP) [*8] |-> O_ERROR_OUT_N_OE)
        else $error("open flag reached error pin while blanked");
    AST_BLANK_OFF: assert property (blank_run >= 5'h18 |-> O_CHANNEL_OUTPUT == 16'h0000)
        else $error("channel on while blanked");
    AST_WRITE_LAT: assert property
        (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID)
        else $error("write response late");
    AST_B_DONE: assert property
        (O_BVALID && I_BREADY |=> !O_BVALID ##1 (O_AWREADY && O_WREADY))
        else $error("write channel not recovered");
    AST_READ_LAT: assert property (I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY)
        else $error("read data late");
    AST_R_DONE: assert property (O_RVALID && I_RREADY |=> !O_RVALID && O_ARREADY)
        else $error("read channel not recovered");
endmodule : lsd_top_monitor

bind lsd_top lsd_top_monitor u_lsd_top_monitor (
    .I_CORE_CLK, .I_RST_B, .I_BLANK, .I_OVER_TEMP, .I_LOW_VOUT, .O_ERROR_OUT_N,
    .O_ERROR_OUT_N_OE, .O_CHANNEL_OUTPUT, .I_AWVALID, .O_AWREADY, .I_WVALID, .O_WREADY,
    .O_BVALID, .I_BREADY, .I_ARVALID, .O_ARREADY, .O_RVALID, .I_RREADY
);

/* File: verification/lsd_top_tb.sv */
// self-checking bench for the serial led sink driver
`timescale 1ns/1ps
module lsd_top_tb;
    logic clk = 1'b0, rst_b = 1'b0, blank = 1'b1, pwm = 1'b0, otemp = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [15:0] lowv = 16'h0000;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic sclk, ser_in, latch, mode, ser_out, oe_n, err_n, irq;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] chan;
    int mismatches = 0, tests_run = 0, cycles = 0;
    // pulled-up open-drain line
    wire logic err_wire = oe_n ? 1'b1 : err_n;

    lsd_top u_lsd_top (
        .I_CORE_CLK(clk), .I_RST_B(rst_b), .I_CE(1'b1), .I_SHIFT_CLK(sclk), .I_SERIAL_IN(ser_in),
        .I_LATCH_STROBE(latch), .I_MODE(mode), .I_BLANK(blank), .I_PWM_COUNT_CLOCK(pwm),
        .I_OVER_TEMP(otemp), .I_LOW_VOUT(lowv), .I_ERROR_OUT_N(err_wire), .O_ERROR_OUT_N(err_n),
        .O_ERROR_OUT_N_OE(oe_n), .O_SERIAL_OUT(ser_out), .O_CHANNEL_OUTPUT(chan), .O_IRQ(irq),
        .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
        .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
        .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
        .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready)
    );
    lsd_host_model u_lsd_host_model (
        .i_clk(clk), .i_serial_out(ser_out), .o_shift_clk(sclk), .o_serial_in(ser_in),
        .o_latch(latch), .o_mode(mode)
    );

    // =====
    // helpers
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic stop_test();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic chk(input logic [191:0] got, input logic [191:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(192'(bresp), 192'(er));
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(192'({rresp, rdata}), 192'({er, d}));
    endtask : axr

    // =====
    // main sequence
    initial begin
        logic [191:0] q, gray;
        logic [95:0] dotc;
        int rise [16];
        int on [16];
        dotc = 96'hA5C3_0F1E_2D3C_4B5A_6978_8796;
        gray = '0;
        for (int n = 0; n < 16; n++) gray[12*n +: 12] = 12'(n);
        cyc(16);
        rst_b <= 1'b1;
        axr(8'h00, 32'h0, 2'b00);
        axr(8'h0C, 32'h0, 2'b00);
        axw(8'h10, 32'h1, 2'b10);
        axr(8'h10, 32'h0, 2'b10);
        u_lsd_host_model.set_mode(1'b1);
        u_lsd_host_model.frame(192'(dotc), 96, q);
        u_lsd_host_model.frame(192'(dotc), 96, q);
        chk(q, 192'(dotc));
        u_lsd_host_model.pulse();
        u_lsd_host_model.set_mode(1'b0);
        u_lsd_host_model.frame(gray, 192, q);
        u_lsd_host_model.pulse();
        u_lsd_host_model.frame('0, 192, q);
        chk(q, {72'h0, dotc, 24'h000000});
        blank <= 1'b0;
        for (int k = 0; k <= 16; k++) begin
            cyc(24);
            for (int n = 0; n < 16; n++) chk(192'(chan[n]), 192'(k < n));
            pwm <= 1'b1;
            cyc(3);
            pwm <= 1'b0;
        end
        // latched mid-cycle on purpose: new values must act at once
        u_lsd_host_model.frame('1, 192, q);
        u_lsd_host_model.pulse();
        cyc(24);
        chk(192'(chan), 192'(16'hFFFF));
        blank <= 1'b1;
        cyc(30);
        chk(192'(chan), 192'(16'h0000));
        for (int n = 0; n < 16; n++) begin
            rise[n] = -1;
            on[n] = 0;
        end
        fork
            begin
                blank <= 1'b0;
                cyc(5);
                blank <= 1'b1;
            end
            for (int t = 0; t < 40; t++) begin
                @(posedge clk);
                for (int n = 0; n < 16; n++) begin
                    if (chan[n] === 1'b1) on[n]++;
                    if (chan[n] === 1'b1 && rise[n] < 0) rise[n] = t;
                end
            end
        join
        for (int n = 0; n < 16; n++) begin
            chk(192'(on[n]), 192'(5));
            chk(192'(rise[n] - rise[0]), 192'(n));
        end
        lowv <= 16'h0004;
        blank <= 1'b0;
        cyc(90);
        axr(8'h04, 32'h0000_0004, 2'b00);
        u_lsd_host_model.frame('1, 192, q);
        u_lsd_host_model.pulse();
        u_lsd_host_model.frame('1, 192, q);
        chk(q, {72'h0, dotc, 24'h000004});
        axr(8'h08, 32'h6, 2'b00);
        chk(192'(irq), 192'(0));
        axw(8'h08, 32'h7, 2'b00);
        axr(8'h08, 32'h0, 2'b00);
        // open flag still live here: only the mask can release the pin this soon
        blank <= 1'b1;
        cyc(5);
        chk(192'(oe_n), 192'(1));
        lowv <= 16'h0000;
        axw(8'h0C, 32'h1, 2'b00);
        otemp <= 1'b1;
        cyc(10);
        chk(192'({irq, oe_n}), 192'(2'b10));
        axr(8'h04, 32'h0001_0000, 2'b00);
        otemp <= 1'b0;
        cyc(10);
        chk(192'(oe_n), 192'(1));
        axr(8'h04, 32'h0004_0000, 2'b00);
        axw(8'h08, 32'h1, 2'b00);
        cyc(2);
        chk(192'(irq), 192'(0));
        axw(8'h00, 32'h1, 2'b00);
        blank <= 1'b0;
        cyc(30);
        chk(192'(chan), 192'(16'h0000));
        axr(8'h00, 32'h1, 2'b00);
        stop_test();
    end
endmodule : lsd_top_tb
